// *** rtl/ibe_engine.sv ***
// i2c master byte engine: transmit, receive, acknowledge and stop sequences
// assumes open-drain scl/sda resolved outside; register port on clk_sys_i
//
// What this block does
// [R01] idle buffer write sets full, starts transmit
// [R02] bit after scl fall; low, high one period
// [R03] seven address bits then direction bit, msb first
// [R04] eighth fall clears full, releases sda
// [R05] ninth fall samples sda into ack status
// [R06] after ninth clock: event flag, counter suspended
// [R07] full set by write, cleared after 8 bits
// [R08] busy write sets collision; early rewrite updates
// [R09] collision flag cleared only by software
// [R10] receive enable honoured only while idle
// [R11] receive: each rollover toggles scl; rollover ending the high phase shifts sda
// [R12] eighth receive fall: copy, flags, scl low
// [R13] receive: buffer read clears full flag
// [R14] overflow when byte completes while full
// [R15] write during receive/ack/stop: collision, unchanged
// [R16] ack sequence pulls scl low, drives ack data
// [R17] ack: period, release, wait high, period, low
// [R18] software picks ack data before ack sequence
// [R19] stop: sda low, period, scl high, period, sda high
// [R20] stop seen sets status, period later event
// [R21] counter reloads from 7-bit rate register
// [R22] counter decrements twice per instruction cycle
// [R23] ack status held until next ninth clock
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ibe_engine
    import ibe_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // i2c pins, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o
);
    // ****************************************
    // state
    // ****************************************
    ibe_state_t q_reg;
    ibe_state_t q_next;
    logic to;

    function automatic logic counting(input ibe_fsm_t s);
        case (s)
            ST_TX_LOW, ST_TX_HIGH, ST_RX_LOW, ST_RX_HIGH, ST_ACK_LOW,
            ST_ACK_HIGH, ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_DONE: counting = 1'b1;
            default: counting = 1'b0;
        endcase
    endfunction : counting

    function automatic logic in_tx(input ibe_fsm_t s);
        in_tx = (s == ST_TX_LOW) || (s == ST_TX_WAIT) || (s == ST_TX_HIGH);
    endfunction : in_tx

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic ld;
        logic [7:0] rx_byte;
        ld = 1'b0;
        to = 1'b0;
        rx_byte = {q_reg.shift[6:0], q_reg.pin_f[PIN_SDA]};
        q_next = q_reg;
        // three-stage pin sampling; a level counts once stages two and three agree
        q_next.pin_s1 = {scl_i, sda_i};
        q_next.pin_s2 = q_reg.pin_s1;
        q_next.pin_s3 = q_reg.pin_s2;
        for (int k = 0; k < 2; k++) begin
            if (q_reg.pin_s2[k] == q_reg.pin_s3[k]) begin
                q_next.pin_f[k] = q_reg.pin_s2[k];
            end
        end
        // rate counter, two decrements per instruction cycle
        if (counting(q_reg.st)) begin
            if (q_reg.pre == 3'h0) begin
                q_next.pre = TICK_LAST; // R22
                if (q_reg.cnt == 7'h00) begin
                    to = 1'b1; // R21
                end else begin
                    q_next.cnt = q_reg.cnt - 7'h01;
                end
            end else begin
                q_next.pre = q_reg.pre - 3'h1;
            end
        end
        if (q_reg.wwin != 5'h00) begin
            q_next.wwin = q_reg.wwin - 5'h01;
        end
        // ****************************************
        // software side; hardware sets below win
        // ****************************************
        q_next.rd_data = 8'h00;
        if (rd_i) begin
            case (addr_i)
                ADDR_BUF: q_next.rd_data = q_reg.xbuf;
                ADDR_STAT: begin
                    q_next.rd_data[STAT_FULL] = q_reg.buffer_full_flag;
                    q_next.rd_data[STAT_STOP] = q_reg.stop_seen;
                end
                ADDR_CON2: begin
                    q_next.rd_data[CON2_STOP] = q_reg.stop_enable_bit;
                    q_next.rd_data[CON2_RECV] = q_reg.receive_enable_bit;
                    q_next.rd_data[CON2_ACKSEQ] = q_reg.ack_sequence_enable;
                    q_next.rd_data[CON2_ACKDATA] = q_reg.ack_data_bit;
                    q_next.rd_data[CON2_ACK_STATUS_BIT] = q_reg.ack_status_bit;
                end
                ADDR_RATE: q_next.rd_data = {1'b0, q_reg.rate};
                ADDR_FLAG: begin
                    q_next.rd_data[FLAG_EVT] = q_reg.port_event_flag;
                    q_next.rd_data[FLAG_COLL] = q_reg.write_collision_flag;
                    q_next.rd_data[FLAG_OVF] = q_reg.receive_overflow_flag;
                end
                default: q_next.rd_data = 8'h00;
            endcase
            if (addr_i == ADDR_BUF && !in_tx(q_reg.st)) begin
                q_next.buffer_full_flag = 1'b0; // R13
            end
        end
        if (wr_i) begin
            case (addr_i)
                ADDR_BUF: begin
                    if (q_reg.st == ST_IDLE) begin
                        q_next.xbuf = wdata_i; // R01
                        q_next.shift = wdata_i;
                        q_next.buffer_full_flag = 1'b1; // R07
                        q_next.bitn = 4'h0;
                        q_next.st = ST_TX_LOW;
                        q_next.scl_low = 1'b1;
                        q_next.sda_low = ~wdata_i[7]; // R03
                        q_next.wwin = WIN_LOAD;
                        q_next.stop_seen = 1'b0;
                        ld = 1'b1;
                    end else begin
                        q_next.write_collision_flag = 1'b1; // R08 R15
                        // a late rewrite is dropped; an early one still lands
                        if (in_tx(q_reg.st) && q_reg.wwin != 5'h00) begin
                            q_next.xbuf = wdata_i; // R08
                        end
                    end
                end
                ADDR_CON2: begin
                    q_next.ack_data_bit = wdata_i[CON2_ACKDATA]; // R18
                    // requests outside idle are ignored, no queueing
                    if (q_reg.st == ST_IDLE) begin
                        if (wdata_i[CON2_STOP]) begin
                            q_next.stop_enable_bit = 1'b1;
                            q_next.sda_low = 1'b1; // R19
                            q_next.stop_seen = 1'b0;
                            q_next.st = ST_STOP_SDA;
                        end else if (wdata_i[CON2_ACKSEQ]) begin
                            q_next.ack_sequence_enable = 1'b1;
                            q_next.scl_low = 1'b1; // R16
                            q_next.sda_low = ~wdata_i[CON2_ACKDATA];
                            q_next.st = ST_ACK_LOW;
                            ld = 1'b1;
                        end else if (wdata_i[CON2_RECV]) begin
                            q_next.receive_enable_bit = 1'b1; // R10
                            q_next.scl_low = 1'b1;
                            q_next.sda_low = 1'b0;
                            q_next.bitn = 4'h0;
                            q_next.stop_seen = 1'b0;
                            q_next.st = ST_RX_LOW;
                            ld = 1'b1;
                        end
                    end
                end
                ADDR_RATE: q_next.rate = wdata_i[6:0]; // R21
                ADDR_FLAG: begin
                    if (wdata_i[FLAG_EVT]) begin
                        q_next.port_event_flag = 1'b0;
                    end
                    if (wdata_i[FLAG_COLL]) begin
                        q_next.write_collision_flag = 1'b0; // R09
                    end
                    if (wdata_i[FLAG_OVF]) begin
                        q_next.receive_overflow_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // ****************************************
        // sequencer
        // ****************************************
        case (q_reg.st)
            ST_IDLE: ;
            ST_TX_LOW, ST_RX_LOW, ST_ACK_LOW: begin
                if (to) begin
                    q_next.scl_low = 1'b0; // R02 R17
                    q_next.st = (q_reg.st == ST_TX_LOW) ? ST_TX_WAIT
                              : (q_reg.st == ST_RX_LOW) ? ST_RX_WAIT : ST_ACK_WAIT;
                end
            end
            ST_TX_WAIT, ST_RX_WAIT, ST_ACK_WAIT: begin
                // a slave stretching scl suspends the count
                if (q_reg.pin_f[PIN_SCL]) begin
                    ld = 1'b1;
                    q_next.st = (q_reg.st == ST_TX_WAIT) ? ST_TX_HIGH
                              : (q_reg.st == ST_RX_WAIT) ? ST_RX_HIGH : ST_ACK_HIGH;
                end
            end
            ST_TX_HIGH: begin
                if (to) begin
                    q_next.scl_low = 1'b1; // R02
                    ld = 1'b1;
                    if (q_reg.bitn == 4'h8) begin
                        q_next.ack_status_bit = q_reg.pin_f[PIN_SDA]; // R05 R23
                        q_next.port_event_flag = 1'b1; // R06
                        q_next.st = ST_IDLE;
                    end else if (q_reg.bitn == 4'h7) begin
                        q_next.buffer_full_flag = 1'b0; // R04 R07
                        q_next.sda_low = 1'b0;
                        q_next.bitn = 4'h8;
                        q_next.st = ST_TX_LOW;
                    end else begin
                        q_next.shift = {q_reg.shift[6:0], 1'b0}; // R03
                        q_next.sda_low = ~q_reg.shift[6];
                        q_next.bitn = q_reg.bitn + 4'h1;
                        q_next.st = ST_TX_LOW;
                    end
                end
            end
            ST_RX_HIGH: begin
                if (to) begin
                    q_next.shift = rx_byte; // R11
                    q_next.scl_low = 1'b1;
                    if (q_reg.bitn == 4'h7) begin
                        q_next.receive_enable_bit = 1'b0; // R12
                        q_next.xbuf = rx_byte;
                        q_next.buffer_full_flag = 1'b1;
                        q_next.port_event_flag = 1'b1;
                        if (q_reg.buffer_full_flag) begin
                            q_next.receive_overflow_flag = 1'b1; // R14
                        end
                        q_next.st = ST_IDLE;
                    end else begin
                        q_next.bitn = q_reg.bitn + 4'h1;
                        ld = 1'b1;
                        q_next.st = ST_RX_LOW;
                    end
                end
            end
            ST_ACK_HIGH: begin
                if (to) begin
                    q_next.scl_low = 1'b1; // R17
                    q_next.ack_sequence_enable = 1'b0;
                    q_next.st = ST_IDLE;
                end
            end
            ST_STOP_SDA: begin
                if (!q_reg.pin_f[PIN_SDA]) begin
                    ld = 1'b1; // R19
                    q_next.st = ST_STOP_LOW;
                end
            end
            ST_STOP_LOW: begin
                if (to) begin
                    q_next.scl_low = 1'b0; // R19
                    ld = 1'b1;
                    q_next.st = ST_STOP_HIGH;
                end
            end
            ST_STOP_HIGH: begin
                if (to) begin
                    q_next.sda_low = 1'b0; // R19
                    q_next.st = ST_STOP_REL;
                end
            end
            ST_STOP_REL: begin
                if (q_reg.pin_f[PIN_SDA] && q_reg.pin_f[PIN_SCL]) begin
                    q_next.stop_seen = 1'b1; // R20
                    ld = 1'b1;
                    q_next.st = ST_STOP_DONE;
                end
            end
            ST_STOP_DONE: begin
                if (to) begin
                    q_next.stop_enable_bit = 1'b0; // R20
                    q_next.port_event_flag = 1'b1;
                    q_next.st = ST_IDLE;
                end
            end
            default: q_next.st = ST_IDLE;
        endcase
        if (ld) begin
            q_next.cnt = q_reg.rate; // R21
            q_next.pre = TICK_LAST;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            q_reg <= '0;
            q_reg.rate <= RATE_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    // pins only ever pulled low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n_o = ~q_reg.scl_low;
    assign sda_oe_n_o = ~q_reg.sda_low;
    assign rdata_o = q_reg.rd_data;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    a_tx_start_full: assert property ( // R01
        (wr_i && addr_i == ADDR_BUF && q_reg.st == ST_IDLE)
        |=> (q_reg.buffer_full_flag && q_reg.st == ST_TX_LOW && !scl_oe_n_o))
        else $error("idle buffer write did not start transmit");
    a_tx_low_hold: assert property ( // R02
        (q_reg.st == ST_TX_LOW) |-> !scl_oe_n_o)
        else $error("scl not held low in transmit low phase");
    a_eighth_release: assert property ( // R04
        (q_reg.st == ST_TX_HIGH && to && q_reg.bitn == 4'h7)
        |=> (sda_oe_n_o && !q_reg.buffer_full_flag && q_reg.bitn == 4'h8))
        else $error("sda not released after eighth bit");
    a_ack_sample: assert property ( // R05
        (q_reg.st == ST_TX_HIGH && to && q_reg.bitn == 4'h8)
        |=> (q_reg.ack_status_bit == $past(q_reg.pin_f[PIN_SDA])
             && q_reg.port_event_flag && q_reg.st == ST_IDLE && !scl_oe_n_o)) // R06
        else $error("ninth clock did not capture ack or raise event");
    a_coll_sticky: assert property ( // R09
        (q_reg.write_collision_flag && !(wr_i && addr_i == ADDR_FLAG
         && wdata_i[FLAG_COLL])) |=> q_reg.write_collision_flag)
        else $error("collision flag cleared without software");
    a_recv_ignored: assert property ( // R10
        (wr_i && addr_i == ADDR_CON2 && q_reg.st != ST_IDLE && !q_reg.receive_enable_bit)
        |=> !q_reg.receive_enable_bit)
        else $error("receive request taken while busy");
    a_rx_complete: assert property ( // R12
        (q_reg.st == ST_RX_HIGH && to && q_reg.bitn == 4'h7)
        |=> (q_reg.buffer_full_flag && q_reg.port_event_flag
             && !q_reg.receive_enable_bit && !scl_oe_n_o && q_reg.st == ST_IDLE))
        else $error("receive completion effects missing");
    a_read_clears: assert property ( // R13
        (rd_i && addr_i == ADDR_BUF && q_reg.st == ST_IDLE) |=> !q_reg.buffer_full_flag)
        else $error("buffer read did not clear full flag");
    a_rx_write_kept: assert property ( // R15
        (wr_i && addr_i == ADDR_BUF && (q_reg.st == ST_RX_LOW || q_reg.st == ST_RX_HIGH))
        |=> (q_reg.write_collision_flag && q_reg.xbuf == $past(q_reg.xbuf)))
        else $error("write during receive changed buffer");
    a_stop_pull: assert property ( // R19
        (q_reg.st == ST_STOP_SDA) |-> (!sda_oe_n_o && q_reg.stop_enable_bit))
        else $error("stop did not pull sda low");

    c_tx_byte: cover property (q_reg.st == ST_TX_HIGH && to && q_reg.bitn == 4'h8);
    c_rx_byte: cover property (q_reg.st == ST_RX_HIGH && to && q_reg.bitn == 4'h7);
    c_ack_done: cover property (q_reg.st == ST_ACK_HIGH && to);
    c_stop_done: cover property (q_reg.st == ST_STOP_DONE && to);
endmodule : ibe_engine
`default_nettype wire

// *** inc/ibe_pkg.sv ***
// constants, state enum and state record of the i2c master byte engine
// assumes a 100 MHz system clock and an instruction cycle modelled in ns
package ibe_pkg;
    // ****************************************
    // register map (word index on a byte port)
    // ****************************************
    localparam logic [2:0] ADDR_BUF = 3'h0;
    localparam logic [2:0] ADDR_STAT = 3'h1;
    localparam logic [2:0] ADDR_CON2 = 3'h2;
    localparam logic [2:0] ADDR_RATE = 3'h3;
    localparam logic [2:0] ADDR_FLAG = 3'h4;
    // status_register fields
    localparam int STAT_FULL = 0;
    localparam int STAT_STOP = 4;
    // control_register_2 fields
    localparam int CON2_STOP = 2;
    localparam int CON2_RECV = 3;
    localparam int CON2_ACKSEQ = 4;
    localparam int CON2_ACKDATA = 5;
    localparam int CON2_ACK_STATUS_BIT = 6;
    // event register fields, write one to clear
    localparam int FLAG_EVT = 0;
    localparam int FLAG_COLL = 1;
    localparam int FLAG_OVF = 2;
    localparam logic [6:0] RATE_RST = 7'h00;
    // pin vector positions
    localparam int PIN_SDA = 0;
    localparam int PIN_SCL = 1;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 10;
    localparam int TCY_NS = 100;
    localparam int TICK_CYC = TCY_NS / (2 * CLK_NS);
    localparam int COLL_WIN_TCY = 2;
    localparam int COLL_WIN_CYC = COLL_WIN_TCY * TCY_NS / CLK_NS;
    localparam logic [2:0] TICK_LAST = 3'(TICK_CYC - 1);
    localparam logic [4:0] WIN_LOAD = 5'(COLL_WIN_CYC);
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE, ST_TX_LOW, ST_TX_WAIT, ST_TX_HIGH, ST_RX_LOW, ST_RX_WAIT,
        ST_RX_HIGH, ST_ACK_LOW, ST_ACK_WAIT, ST_ACK_HIGH, ST_STOP_SDA,
        ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_REL, ST_STOP_DONE
    } ibe_fsm_t;
    typedef struct packed {
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [1:0] pin_s3;
        logic [1:0] pin_f;
        ibe_fsm_t st;
        logic [6:0] cnt;
        logic [2:0] pre;
        logic [6:0] rate;
        logic [3:0] bitn;
        logic [7:0] shift;
        logic [7:0] xbuf;
        logic [4:0] wwin;
        logic [7:0] rd_data;
        logic scl_low;
        logic sda_low;
        logic buffer_full_flag;
        logic stop_seen;
        logic receive_enable_bit;
        logic ack_sequence_enable;
        logic stop_enable_bit;
        logic ack_data_bit;
        logic ack_status_bit;
        logic port_event_flag;
        logic write_collision_flag;
        logic receive_overflow_flag;
    } ibe_state_t;
endpackage : ibe_pkg

// *** dv/ibe_slave.sv ***
// i2c slave model facing the byte engine: takes bytes, answers ack, sends bytes
// assumes resolved open-drain wires with pull-ups, sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module ibe_slave (
    // clock and control
    input wire logic clk_sys_i,
    input wire logic clr_i,
    input wire logic mode_rx_i,
    input wire logic ack_i,
    input wire logic [7:0] txb_i,
    input wire logic [7:0] stretch_i,
    // bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_pull_o,
    output logic sda_pull_o,
    output logic [8:0] rx9_o
);
    logic scl_q;
    logic [3:0] rc;
    logic [3:0] idx;
    logic [7:0] scnt;
    // bit index moves only on a falling edge, so data never changes while scl is high
    assign idx = scl_q ? rc - 4'h1 : rc;
    assign scl_pull_o = (scnt != 8'h00);
    always_comb begin
        if (mode_rx_i) begin
            sda_pull_o = (idx < 4'h8) && !txb_i[3'(4'h7 - idx)];
        end else begin
            sda_pull_o = ack_i && (((rc == 4'h8) && !scl_q) || ((rc == 4'h9) && scl_q));
        end
    end
    always_ff @(posedge clk_sys_i) begin
        scl_q <= scl_i;
        if (clr_i) begin
            rc <= 4'h0;
            rx9_o <= 9'h000;
            scnt <= 8'h00;
        end else begin
            if (scl_i && !scl_q) begin
                rc <= rc + 4'h1;
                rx9_o <= {rx9_o[7:0], sda_i};
            end
            // slow answer: hold scl low after each fall
            if (!scl_i && scl_q) begin
                scnt <= stretch_i;
            end else if (scnt != 8'h00) begin
                scnt <= scnt - 8'h01;
            end
        end
    end
endmodule : ibe_slave
`default_nettype wire

// *** dv/i2c_master_byte_engine_bench.sv ***
// self-checking bench for the i2c master byte engine
// assumes the slave model on the far side and pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
module i2c_master_byte_engine_bench import ibe_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o, v, b;
    logic scl_oe_n, sda_oe_n, scl_o, sda_o, scl_w, sda_w, s_scl, s_sda;
    logic clr = 1'b1;
    logic mode_rx = 1'b0;
    logic ack_en = 1'b1;
    logic [7:0] txb = 8'h00;
    logic [7:0] stretch = 8'h00;
    logic [8:0] rx9;
    int err_total = 0;
    int comparisons = 0;
    int lo_cyc = 0;
    assign scl_w = (scl_oe_n ? 1'b1 : scl_o) & !s_scl;
    assign sda_w = (sda_oe_n ? 1'b1 : sda_o) & !s_sda;
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    ibe_engine u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n));
    ibe_slave u_slave (.clk_sys_i(clk_sys_i), .clr_i(clr), .mode_rx_i(mode_rx),
        .ack_i(ack_en), .txb_i(txb), .stretch_i(stretch), .scl_i(scl_w), .sda_i(sda_w),
        .scl_pull_o(s_scl), .sda_pull_o(s_sda), .rx9_o(rx9));
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic chk(input string w, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", w, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd
    task automatic rdchk(input string w, input logic [2:0] a, input logic [7:0] e);
        rd(a, v);
        chk(w, v, e);
    endtask : rdchk
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    // bounded poll; a bit that never arrives ends the run
    task automatic wait_bit(input logic [2:0] a, input int n, input logic val);
        for (int k = 0; k < 3000; k++) begin
            rd(a, v);
            if (v[n] === val) return;
        end
        err_total++;
        $display("BAD wait reg %0d expected %b seen %b", a, val, v[n]);
        results();
    endtask : wait_bit
    task automatic prep(input logic rx, input logic ak, input logic [7:0] st, input logic [7:0] tb);
        @(posedge clk_sys_i);
        mode_rx <= rx;
        ack_en <= ak;
        stretch <= st;
        txb <= tb;
        clr <= 1'b1;
        @(posedge clk_sys_i);
        clr <= 1'b0;
    endtask : prep
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        clr <= 1'b0;
        for (int a = 0; a < 6; a++) rdchk("reset reg", 3'(a), 8'h00);
        chk("reset lines", {6'h00, scl_oe_n, sda_oe_n}, 8'h03);
        wr(ADDR_RATE, 8'h83);
        rdchk("rate", ADDR_RATE, 8'h03);
        $display("test reset done");
        wr(ADDR_BUF, 8'hA5);
        #1 chk("scl low", {7'h00, scl_oe_n}, 8'h00);
        rdchk("full set", ADDR_STAT, 8'h01);
        wr(ADDR_BUF, 8'h3C);
        rdchk("early coll", ADDR_FLAG, 8'h02);
        rdchk("early buf", ADDR_BUF, 8'h3C);
        repeat (25) @(posedge clk_sys_i);
        wr(ADDR_BUF, 8'h77);
        rdchk("late buf", ADDR_BUF, 8'h3C);
        wait_bit(ADDR_FLAG, FLAG_EVT, 1'b1);
        rdchk("tx flags", ADDR_FLAG, 8'h03);
        chk("tx byte", rx9[8:1], 8'hA5);
        rdchk("ack stat", ADDR_CON2, 8'h00);
        rdchk("full clr", ADDR_STAT, 8'h00);
        chk("scl held", {7'h00, scl_oe_n}, 8'h00);
        wr(ADDR_FLAG, 8'h03);
        prep(1'b0, 1'b0, 8'd30, 8'h00);
        wr(ADDR_BUF, 8'h96);
        wr(ADDR_CON2, 8'h08);
        wait_bit(ADDR_FLAG, FLAG_EVT, 1'b1);
        rdchk("nack stat", ADDR_CON2, 8'h40);
        chk("slow byte", rx9[8:1], 8'h96);
        wr(ADDR_FLAG, 8'h07);
        $display("test transmit done");
        for (int i = 0; i < 2; i++) begin
            b = (i == 0) ? 8'hC3 : 8'h5A;
            prep(1'b1, 1'b0, 8'h00, b);
            wr(ADDR_CON2, 8'h08);
            if (i == 0) begin
                repeat (30) @(posedge clk_sys_i);
                wr(ADDR_BUF, 8'hFF);
                rdchk("rx coll", ADDR_FLAG, 8'h02);
                rdchk("rx buf", ADDR_BUF, 8'h96);
            end
            wait_bit(ADDR_FLAG, FLAG_EVT, 1'b1);
            rdchk("rx flags", ADDR_FLAG, (i == 0) ? 8'h03 : 8'h05);
            rdchk("rx full", ADDR_STAT, 8'h01);
            rdchk("rx con2", ADDR_CON2, 8'h40);
            chk("rx wire", rx9[7:0], b);
            wr(ADDR_FLAG, 8'h07);
            wr(ADDR_CON2, (i == 0) ? 8'h10 : 8'h30);
            #1 chk("ack start", {6'h00, scl_oe_n, sda_oe_n}, 8'(i));
            // scl low time of the ack: one rate period at two counts per instruction cycle
            lo_cyc = 0;
            while (!scl_oe_n && lo_cyc < 100) begin
                @(posedge clk_sys_i);
                #1;
                lo_cyc++;
            end
            chk("ack low cycles", 8'(lo_cyc), 8'((3 + 1) * TICK_CYC));
            wait_bit(ADDR_CON2, CON2_ACKSEQ, 1'b0);
            chk("ack bit", {7'h00, rx9[0]}, 8'(i));
            chk("ack scl", {7'h00, scl_oe_n}, 8'h00);
        end
        rdchk("rx data", ADDR_BUF, 8'h5A);
        rdchk("read clr", ADDR_STAT, 8'h00);
        $display("test receive done");
        wr(ADDR_CON2, 8'h24);
        #1 chk("stop sda", {7'h00, sda_oe_n}, 8'h00);
        repeat (15) @(posedge clk_sys_i);
        wr(ADDR_BUF, 8'h11);
        wait_bit(ADDR_FLAG, FLAG_EVT, 1'b1);
        rdchk("stop flags", ADDR_FLAG, 8'h03);
        rdchk("stop seen", ADDR_STAT, 8'h10);
        rdchk("stop con2", ADDR_CON2, 8'h60);
        rdchk("stop buf", ADDR_BUF, 8'h5A);
        chk("stop lines", {6'h00, scl_w, sda_w}, 8'h03);
        $display("test stop done");
        results();
    end
endmodule : i2c_master_byte_engine_bench
`default_nettype wire
